// File: verilog/ccd_top.sv
// cascaded channel divider: channel three two-stage divider, channel four first stage
// assumes clk is the divider input clock and sync_n is synchronous to it
//
// Overview of operation
// (RL1) Channel three stage one stays low for its low count plus one input cycles.
// (RL2) Channel three stage one stays high for its high count plus one input cycles.
// (RL3) A count of zero gives one input cycle and all count fields reset to zero.
// (RL4) Channel three stage two has its own low and high counts in a separate register.
// (RL5) Channel three has a phase offset per stage, stage two high nibble, both reset zero.
// (RL6) Stage two bypass stops that counter and passes its input clock straight through; with stage one also bypassed ch3_out stays low, ch3_direct set.
// (RL7) Stage one bypass stops that counter and passes its input clock straight through.
// (RL8) With ignore-alignment clear the channel follows the chip sync, when set it ignores it.
// (RL9) Force level drives the output high or low, and needs ignore-alignment set to apply; here it drives ch3_out only while sync_n is low.
// (RL10) Stage two starts its waveform at the level chosen by its start bit.
// (RL11) Stage one starts its waveform at the level chosen by its start bit.
// (RL12) Duty-cycle correction runs while the disable bit is zero and is skipped when one.
// (RL13) Channel four stage one has its own low and high counts resetting to zero.
// (RL14) Channel four has a phase offset per stage, both resetting to zero; only the stage one offset in the low nibble is used here.
// (RL15) Stage two runs on stage one's output so the division is the product of both.
// (RL16) After a sync each stage waits its phase offset and restarts at its start level.
`include "ccd_defines.svh"

module ccd_top (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // chip-level output sync, low while asserted
   input wire logic sync_n,
   // divided channel outputs
   output logic ch3_out,
   output logic ch3_direct,
   output logic ch4_out
);

   logic [7:0] c3_s1, c3_ph, c3_s2, c3_ctl, c3_dcc, c4_s1, c4_ph;
   logic [7:0] next_c3_s1, next_c3_ph, next_c3_s2, next_c3_ctl, next_c3_dcc;
   logic [7:0] next_c4_s1, next_c4_ph;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic next_ch3_out, next_ch3_direct, next_ch4_out;
   logic c3_hold, c4_hold, wr_take;
   logic s1_level, s1_rise, s2_level, s2_in_en, c4_level;

   // byte address of a register index
   function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
      reg_hit = (addr == {idx, 2'b00});
   endfunction

   // any of the seven mapped registers
   function automatic logic reg_mapped(input logic [11:0] addr);
      reg_mapped = reg_hit(addr, `CCD_IDX_C3_S1) || reg_hit(addr, `CCD_IDX_C3_PH)
         || reg_hit(addr, `CCD_IDX_C3_S2) || reg_hit(addr, `CCD_IDX_C3_CTL)
         || reg_hit(addr, `CCD_IDX_C3_DCC) || reg_hit(addr, `CCD_IDX_C4_S1)
         || reg_hit(addr, `CCD_IDX_C4_PH);
   endfunction

   // one wait state: the answer comes in the cycle after the request appears
   always_comb begin
      next_waitrequest = 1'b1;
      if (avs_waitrequest)
         next_waitrequest = !(avs_read || avs_write);
   end

   // write takes effect only at the edge where waitrequest is low
   assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];

   // register file next values
   always_comb begin
      next_c3_s1 = c3_s1;
      next_c3_ph = c3_ph;
      next_c3_s2 = c3_s2;
      next_c3_ctl = c3_ctl;
      next_c3_dcc = c3_dcc;
      next_c4_s1 = c4_s1;
      next_c4_ph = c4_ph;
      if (wr_take) begin
         if (reg_hit(avs_address, `CCD_IDX_C3_S1))
            next_c3_s1 = avs_writedata[7:0]; // RL1 RL2
         if (reg_hit(avs_address, `CCD_IDX_C3_PH))
            next_c3_ph = avs_writedata[7:0]; // RL5
         if (reg_hit(avs_address, `CCD_IDX_C3_S2))
            next_c3_s2 = avs_writedata[7:0]; // RL4
         if (reg_hit(avs_address, `CCD_IDX_C3_CTL))
            next_c3_ctl = avs_writedata[7:0] & `CCD_CTL_MASK;
         if (reg_hit(avs_address, `CCD_IDX_C3_DCC))
            next_c3_dcc = {7'h00, avs_writedata[`CCD_DCC_OFF]};
         if (reg_hit(avs_address, `CCD_IDX_C4_S1))
            next_c4_s1 = avs_writedata[7:0]; // RL13
         if (reg_hit(avs_address, `CCD_IDX_C4_PH))
            next_c4_ph = avs_writedata[7:0]; // RL14
      end
   end

   // read data, sampled while the request waits; unmapped reads give zero
   always_comb begin
      next_readdata = avs_readdata;
      if (avs_read && avs_waitrequest) begin
         next_readdata = 32'h0000_0000;
         if (reg_hit(avs_address, `CCD_IDX_C3_S1))
            next_readdata[7:0] = c3_s1;
         if (reg_hit(avs_address, `CCD_IDX_C3_PH))
            next_readdata[7:0] = c3_ph;
         if (reg_hit(avs_address, `CCD_IDX_C3_S2))
            next_readdata[7:0] = c3_s2;
         if (reg_hit(avs_address, `CCD_IDX_C3_CTL))
            next_readdata[7:0] = c3_ctl;
         if (reg_hit(avs_address, `CCD_IDX_C3_DCC))
            next_readdata[7:0] = c3_dcc;
         if (reg_hit(avs_address, `CCD_IDX_C4_S1))
            next_readdata[7:0] = c4_s1;
         if (reg_hit(avs_address, `CCD_IDX_C4_PH))
            next_readdata[7:0] = c4_ph;
      end
   end

   // bus and register state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         c3_s1 <= `CCD_RST_REG; // RL3
         c3_ph <= `CCD_RST_REG; // RL5
         c3_s2 <= `CCD_RST_REG; // RL3
         c3_ctl <= `CCD_RST_REG;
         c3_dcc <= `CCD_RST_REG;
         c4_s1 <= `CCD_RST_REG; // RL13
         c4_ph <= `CCD_RST_REG; // RL14
      end else begin
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
         c3_s1 <= next_c3_s1;
         c3_ph <= next_c3_ph;
         c3_s2 <= next_c3_s2;
         c3_ctl <= next_c3_ctl;
         c3_dcc <= next_c3_dcc;
         c4_s1 <= next_c4_s1;
         c4_ph <= next_c4_ph;
      end
   end

   // sync holds the counters only where the channel obeys it
   assign c3_hold = !sync_n && !c3_ctl[`CCD_CTL_NOSYNC]; // RL8
   // channel four has no ignore control in this block, so it always obeys
   assign c4_hold = !sync_n;

   // stage two advances on stage one's rising edges
   assign s2_in_en = s1_rise; // RL15

   ccd_stage u_c3_s1 (
      .clk(clk),
      .arst_n(arst_n),
      .in_en(1'b1),
      .bypass(c3_ctl[`CCD_CTL_BYP1]), // RL7
      .hold(c3_hold),
      .start_high(c3_ctl[`CCD_CTL_START1]), // RL11
      .dcc_en(1'b0),
      .lo_cnt(c3_s1[`CCD_HI_NIB]), // RL1
      .hi_cnt(c3_s1[`CCD_LO_NIB]), // RL2
      .phase(c3_ph[`CCD_LO_NIB]), // RL5
      .level(s1_level),
      .out_rise(s1_rise)
   );

   // correction acts on the final stage, whose output leaves the channel
   ccd_stage u_c3_s2 (
      .clk(clk),
      .arst_n(arst_n),
      .in_en(s2_in_en),
      .bypass(c3_ctl[`CCD_CTL_BYP2]), // RL6
      .hold(c3_hold),
      .start_high(c3_ctl[`CCD_CTL_START2]), // RL10
      .dcc_en(!c3_dcc[`CCD_DCC_OFF]), // RL12
      .lo_cnt(c3_s2[`CCD_HI_NIB]), // RL4
      .hi_cnt(c3_s2[`CCD_LO_NIB]), // RL4
      .phase(c3_ph[`CCD_HI_NIB]), // RL5
      .level(s2_level),
      .out_rise()
   );

   ccd_stage u_c4_s1 (
      .clk(clk),
      .arst_n(arst_n),
      .in_en(1'b1),
      .bypass(1'b0),
      .hold(c4_hold),
      .start_high(1'b0),
      .dcc_en(1'b0),
      .lo_cnt(c4_s1[`CCD_HI_NIB]), // RL13
      .hi_cnt(c4_s1[`CCD_LO_NIB]), // RL13
      .phase(c4_ph[`CCD_LO_NIB]), // RL14
      .level(c4_level),
      .out_rise()
   );

   // output select; a fully bypassed path cannot be shown at clk rate, so flag it
   always_comb begin
      next_ch3_direct = c3_ctl[`CCD_CTL_BYP1] && c3_ctl[`CCD_CTL_BYP2]; // RL6 RL7
      if (c3_ctl[`CCD_CTL_NOSYNC] && !sync_n)
         next_ch3_out = c3_ctl[`CCD_CTL_FORCE]; // RL9
      else if (!c3_ctl[`CCD_CTL_BYP2])
         next_ch3_out = s2_level;
      else if (!c3_ctl[`CCD_CTL_BYP1])
         next_ch3_out = s1_level;
      else
         next_ch3_out = 1'b0;
      next_ch4_out = c4_level;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ch3_out <= 1'b0;
         ch3_direct <= 1'b0;
         ch4_out <= 1'b0;
      end else begin
         ch3_out <= next_ch3_out;
         ch3_direct <= next_ch3_direct;
         ch4_out <= next_ch4_out;
      end
   end

   sequence s_req_waiting;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_forced_sync;
      c3_ctl[`CCD_CTL_NOSYNC] && !sync_n;
   endsequence

   sequence s_read_waiting;
      avs_read && avs_waitrequest;
   endsequence

   a_wait_one: assert property (@(posedge clk) disable iff (!arst_n)
      s_req_waiting |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not a single low cycle after request");

   a_write_count: assert property (@(posedge clk) disable iff (!arst_n) // RL1 RL2
      (wr_take && avs_address == {`CCD_IDX_C3_S1, 2'b00}) |=> c3_s1 == $past(avs_writedata[7:0]))
      else $error("stage one count write lost");

   a_force_level: assert property (@(posedge clk) disable iff (!arst_n) // RL9
      s_forced_sync |=> ch3_out == $past(c3_ctl[`CCD_CTL_FORCE]))
      else $error("forced level not on channel output");

   a_sync_obey: assert property (@(posedge clk) disable iff (!arst_n) // RL8
      (!sync_n && !c3_ctl[`CCD_CTL_NOSYNC] && !c3_ctl[`CCD_CTL_BYP1]) [*2]
      |-> s1_level == $past(c3_ctl[`CCD_CTL_START1]))
      else $error("channel three ignored sync while obeying");

   a_chain_clock: assert property (@(posedge clk) disable iff (!arst_n) // RL15
      (!c3_ctl[`CCD_CTL_BYP1] && !c3_ctl[`CCD_CTL_BYP2] && !c3_hold && $changed(s2_level)
       && !$past(c3_hold) && !$past(c3_hold, 2) && !$past(c3_ctl[`CCD_CTL_BYP2])
       && !$past(c3_ctl[`CCD_CTL_BYP2], 2))
      |-> $past(s1_rise))
      else $error("stage two moved without a stage one edge");

   // bus side: unmapped and disabled accesses, read path, reserved bits
   a_unmapped_read: assert property (@(posedge clk) disable iff (!arst_n)
      s_read_waiting ##0 !reg_mapped(avs_address) |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read did not return zero");

   a_read_path: assert property (@(posedge clk) disable iff (!arst_n) // RL1 RL2
      s_read_waiting ##0 reg_hit(avs_address, `CCD_IDX_C3_S1)
      |=> avs_readdata == {24'h000000, $past(c3_s1)})
      else $error("stage one count read back wrong");

   a_byte_skip: assert property (@(posedge clk) disable iff (!arst_n)
      (avs_write && !avs_waitrequest && !avs_byteenable[0])
      |=> $stable(c3_s1) && $stable(c3_ctl) && $stable(c4_s1))
      else $error("write without byte zero enable changed a register");

   a_ctl_reserved: assert property (@(posedge clk) disable iff (!arst_n)
      c3_ctl[7:6] == 2'b00 && c3_dcc[7:1] == 7'h00)
      else $error("reserved control bits set");

   // output side: source selection, bypass flag and channel four hold
   a_normal_out: assert property (@(posedge clk) disable iff (!arst_n) // RL15
      (!c3_ctl[`CCD_CTL_BYP2] && !(c3_ctl[`CCD_CTL_NOSYNC] && !sync_n))
      |=> ch3_out == $past(s2_level))
      else $error("channel three output not taken from stage two");

   a_stage_skip: assert property (@(posedge clk) disable iff (!arst_n) // RL6
      (c3_ctl[`CCD_CTL_BYP2] && !c3_ctl[`CCD_CTL_BYP1]
       && !(c3_ctl[`CCD_CTL_NOSYNC] && !sync_n))
      |=> ch3_out == $past(s1_level))
      else $error("bypassed stage two did not pass stage one");

   a_direct_flag: assert property (@(posedge clk) disable iff (!arst_n) // RL6 RL7
      1'b1 |=> ch3_direct == $past(c3_ctl[`CCD_CTL_BYP1] && c3_ctl[`CCD_CTL_BYP2]))
      else $error("direct flag disagrees with the bypass bits");

   // channel four has no ignore bit, so a sync always parks it low
   a_ch4_hold: assert property (@(posedge clk) disable iff (!arst_n) // RL16
      !sync_n ##1 !sync_n |=> !ch4_out)
      else $error("channel four not held low by sync");

endmodule

// File: verilog/ccd_defines.svh
// register indices, field positions and reset values of the channel divider block
// assumes a 32-bit avalon-mm slave where byte address = 4 * register index
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// register indices as printed; byte address is index times four
`define CCD_IDX_C3_S1 10'h199
`define CCD_IDX_C3_PH 10'h19a
`define CCD_IDX_C3_S2 10'h19b
`define CCD_IDX_C3_CTL 10'h19c
`define CCD_IDX_C3_DCC 10'h19d
`define CCD_IDX_C4_S1 10'h19e
`define CCD_IDX_C4_PH 10'h19f

// every register of this block comes out of reset at zero
`define CCD_RST_REG 8'h00

// nibble fields: low count / second stage phase high, high count / first stage phase low
`define CCD_HI_NIB 7:4
`define CCD_LO_NIB 3:0

// control bits of the channel three control register
`define CCD_CTL_BYP2 5
`define CCD_CTL_BYP1 4
`define CCD_CTL_NOSYNC 3
`define CCD_CTL_FORCE 2
`define CCD_CTL_START2 1
`define CCD_CTL_START1 0
`define CCD_CTL_MASK 8'h3f

// duty-cycle correction disable bit
`define CCD_DCC_OFF 0

`endif

// File: verilog/ccd_pkg.sv
// types shared by the channel divider block
// assumes ccd_defines.svh carries all numeric constants
package ccd_pkg;

   // divider stage sequencing
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN = 2'b10
   } ccd_state_t;

endpackage

// File: verilog/ccd_stage.sv
// one divider stage: low/high counts, phase delay, start level, bypass
// assumes in_en marks one edge of the stage's input clock, all on clk
`include "ccd_defines.svh"

module ccd_stage (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // input clock events
   input wire logic in_en,
   // configuration
   input wire logic bypass,
   input wire logic hold,
   input wire logic start_high,
   input wire logic dcc_en,
   input wire logic [3:0] lo_cnt,
   input wire logic [3:0] hi_cnt,
   input wire logic [3:0] phase,
   // divided output
   output logic level,
   output logic out_rise
);

   ccd_pkg::ccd_state_t state, next_state;
   logic [5:0] cnt, next_cnt;
   logic next_level, rise_q, next_rise;
   logic [5:0] run_ticks, next_run_ticks;
   logic [3:0] ld_val, next_ld_val;
   logic ld_dcc, next_ld_dcc;

   // length of one level in input cycles; correction splits the period in half, the low level taking any odd cycle
   function automatic logic [5:0] seg_len(input logic lvl, input logic [3:0] lo,
                                          input logic [3:0] hi, input logic dcc);
      logic [5:0] total;
      total = 6'({2'b00, lo} + {2'b00, hi} + 6'h02);
      if (dcc)
         seg_len = lvl ? (total >> 1) : 6'(total - (total >> 1));
      else
         seg_len = lvl ? 6'({2'b00, hi} + 6'h01) : 6'({2'b00, lo} + 6'h01);
   endfunction

   // next state of the counter
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_level = level;
      next_rise = 1'b0;
      next_ld_val = ld_val;
      next_ld_dcc = ld_dcc;
      if (bypass) begin
         next_state = ccd_pkg::ST_IDLE; // RL6 RL7
         next_cnt = 6'h00;
         next_level = 1'b0;
      end else if (hold) begin
         next_state = ccd_pkg::ST_IDLE; // RL16
         next_level = start_high; // RL10 RL11
         next_cnt = 6'h00;
      end else begin
         unique case (state)
            ccd_pkg::ST_IDLE: begin
               next_state = ccd_pkg::ST_DELAY;
               next_level = start_high; // RL10 RL11
               next_cnt = {2'b00, phase}; // RL16
            end
            ccd_pkg::ST_DELAY: begin
               if (cnt == 6'h00) begin
                  next_state = ccd_pkg::ST_RUN;
                  next_cnt = 6'(seg_len(level, lo_cnt, hi_cnt, dcc_en) - 6'h01);
                  next_ld_val = level ? hi_cnt : lo_cnt;
                  next_ld_dcc = dcc_en;
               end else if (in_en) begin
                  next_cnt = 6'(cnt - 6'h01); // RL16
               end
            end
            ccd_pkg::ST_RUN: begin
               if (in_en) begin
                  if (cnt == 6'h00) begin
                     // count of zero still gives one input cycle
                     next_level = ~level; // RL1 RL2 RL3
                     next_rise = ~level;
                     next_cnt = 6'(seg_len(~level, lo_cnt, hi_cnt, dcc_en) - 6'h01);
                     // field kept as loaded, since software may rewrite it mid-segment
                     next_ld_val = level ? lo_cnt : hi_cnt;
                     next_ld_dcc = dcc_en;
                  end else begin
                     next_cnt = 6'(cnt - 6'h01);
                  end
               end
            end
            default: begin
               next_state = ccd_pkg::ST_IDLE;
               next_cnt = 6'h00;
            end
         endcase
      end
   end

   // helper for checking segment lengths
   always_comb begin
      next_run_ticks = 6'h00;
      if (state == ccd_pkg::ST_RUN && !hold && !bypass) begin
         if (in_en)
            next_run_ticks = (next_level != level) ? 6'h00 : 6'(run_ticks + 6'h01);
         else
            next_run_ticks = run_ticks;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ccd_pkg::ST_IDLE;
         cnt <= 6'h00;
         level <= 1'b0;
         rise_q <= 1'b0;
         run_ticks <= 6'h00;
         ld_val <= 4'h0;
         ld_dcc <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         level <= next_level;
         rise_q <= next_rise;
         run_ticks <= next_run_ticks;
         ld_val <= next_ld_val;
         ld_dcc <= next_ld_dcc;
      end
   end

   // bypassed stage hands its input clock straight on
   assign out_rise = bypass ? in_en : rise_q; // RL6 RL7

   a_bypass_pass: assert property (@(posedge clk) disable iff (!arst_n) // RL6 RL7
      bypass |-> (out_rise == in_en) ##1 (state == ccd_pkg::ST_IDLE))
      else $error("bypassed stage does not pass its input");

   a_hold_start: assert property (@(posedge clk) disable iff (!arst_n) // RL10 RL11
      (hold && !bypass) ##1 (hold && !bypass) |-> level == $past(start_high))
      else $error("held stage not at its start level");

   a_high_len: assert property (@(posedge clk) disable iff (!arst_n) // RL2 RL3
      ($fell(level) && state == ccd_pkg::ST_RUN && $past(state) == ccd_pkg::ST_RUN
       && !$past(ld_dcc) && !$past(hold)) |-> $past(run_ticks) == {2'b00, $past(ld_val)})
      else $error("high time differs from high count plus one");

   a_low_len: assert property (@(posedge clk) disable iff (!arst_n) // RL1 RL3
      ($rose(level) && state == ccd_pkg::ST_RUN && $past(state) == ccd_pkg::ST_RUN
       && !$past(ld_dcc) && !$past(hold)) |-> $past(run_ticks) == {2'b00, $past(ld_val)})
      else $error("low time differs from low count plus one");

   a_phase_wait: assert property (@(posedge clk) disable iff (!arst_n) // RL16
      (state == ccd_pkg::ST_DELAY && cnt != 6'h00 && !in_en && !hold && !bypass)
      |=> state == ccd_pkg::ST_DELAY && $stable(cnt) && $stable(level))
      else $error("phase delay left early");

endmodule

// File: sim/ccd_clk_sink.sv
// downstream clock input: measures the last complete high and low run of a clock line
// assumes the line is sampled on clk and comes out of reset low
module ccd_clk_sink (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // observed clock line
   input wire logic clk_in,
   // last measured run lengths in clk cycles
   output logic [7:0] hi_len,
   output logic [7:0] lo_len
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] run;
   logic prev;

   // run length counter; a level change closes the run of the previous level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         run <= 8'h00;
         prev <= 1'b0;
         hi_len <= 8'h00;
         lo_len <= 8'h00;
      end else begin
         prev <= clk_in;
         if (clk_in !== prev) begin
            if (prev) begin
               hi_len <= run;
            end else begin
               lo_len <= run;
            end
            run <= 8'h01;
         end else if (run != 8'hff) begin
            run <= run + 8'h01; // saturates so a stuck line reads as very long
         end
      end
   end
endmodule

// File: sim/testbench.sv
// register bus and divider output checks of the channel divider block
// assumes ccd_top answers each avalon request after one wait cycle
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, arst_n, avs_read, avs_write, avs_waitrequest, sync_n;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic ch3_out, ch3_direct, ch4_out;
   logic [7:0] s3_hi, s3_lo, s4_hi, s4_lo, rd;
   int n_fail, n_tests, d0, d1;

   ccd_top u_ccd_top (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sync_n(sync_n), .ch3_out(ch3_out),
      .ch3_direct(ch3_direct), .ch4_out(ch4_out));
   ccd_clk_sink u_sink3 (.clk(clk), .arst_n(arst_n), .clk_in(ch3_out),
      .hi_len(s3_hi), .lo_len(s3_lo));
   ccd_clk_sink u_sink4 (.clk(clk), .arst_n(arst_n), .clk_in(ch4_out),
      .hi_len(s4_hi), .lo_len(s4_lo));

   // 125 mhz divider input clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   // waits for the accepting edge; a hang counts as a mismatch
   task automatic bus_wait();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         $display("Error at %0t: bus timeout", $time);
         test_done();
      end
   endtask

   task automatic bus_wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] be);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      bus_wait();
      avs_write <= 1'b0;
      @(posedge clk); // idle edge so a following request never re-raises a strobe in this step
   endtask

   task automatic bus_rd(input logic [9:0] idx, output logic [7:0] d);
      avs_address <= {idx, 2'b00};
      avs_read <= 1'b1;
      bus_wait();
      d = avs_readdata[7:0];
      chk({8'h00, avs_readdata[31:8]}, 32'h0); // upper bits read zero
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      bus_rd(idx, v);
      chk({24'h0, v}, {24'h0, exp});
   endtask

   // sync pulse, then cycles from release until ch4 first rises
   task automatic sync_pulse(output int d);
      sync_n <= 1'b0;
      repeat (4) @(posedge clk);
      sync_n <= 1'b1;
      d = 0;
      @(posedge clk);
      while (ch4_out !== 1'b1 && d < 100) begin
         @(posedge clk);
         d++;
      end
      if (d >= 100) begin
         n_fail++;
         $display("Error at %0t: no edge after sync", $time);
         test_done();
      end
      repeat (120) @(posedge clk);
   endtask

   // count tables: stage value, expected high run, expected low run
   logic [7:0] c4_val [3] = '{8'h00, 8'hf3, 8'h4a};
   logic [7:0] c4_hi [3] = '{8'd1, 8'd4, 8'd11};
   logic [7:0] c4_lo [3] = '{8'd1, 8'd16, 8'd5};

   initial begin
      n_fail = 0;
      n_tests = 0;
      arst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 12'h000;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      sync_n = 1'b1;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);

      // reset values, readback, masking, unmapped and disabled writes
      for (int i = 'h199; i <= 'h19f; i++) rd_chk(i[9:0], 8'h00);
      for (int i = 'h199; i <= 'h19f; i++) bus_wr(i[9:0], 8'ha5, 4'hf);
      bus_wr(10'h19c, 8'hff, 4'hf);
      bus_wr(10'h19d, 8'h01, 4'hf);
      bus_wr(10'h1a0, 8'h77, 4'hf);
      bus_wr(10'h199, 8'h3c, 4'he);
      rd_chk(10'h199, 8'ha5);
      rd_chk(10'h19a, 8'ha5);
      rd_chk(10'h19b, 8'ha5);
      rd_chk(10'h19c, 8'h3f);
      rd_chk(10'h19d, 8'h01);
      rd_chk(10'h19e, 8'ha5);
      rd_chk(10'h19f, 8'ha5);
      rd_chk(10'h1a0, 8'h00);
      for (int i = 'h199; i <= 'h19f; i++) bus_wr(i[9:0], 8'h00, 4'hf);
      $display("test registers done");

      // channel four first stage run lengths
      for (int k = 0; k < 3; k++) begin
         bus_wr(10'h19e, c4_val[k], 4'hf);
         sync_pulse(d0);
         chk({24'h0, s4_hi}, {24'h0, c4_hi[k]});
         chk({24'h0, s4_lo}, {24'h0, c4_lo[k]});
      end
      $display("test channel four counts done");

      // phase offset delays the first edge after sync by that many input cycles
      bus_wr(10'h19e, 8'h11, 4'hf);
      sync_pulse(d0);
      bus_wr(10'h19f, 8'h05, 4'hf);
      sync_pulse(d1);
      chk(d1 - d0, 32'd5);
      $display("test phase done");

      // stage one bypassed: stage two counts clk, with and without correction
      bus_wr(10'h19c, 8'h10, 4'hf);
      bus_wr(10'h19b, 8'h31, 4'hf);
      bus_wr(10'h19d, 8'h01, 4'hf);
      sync_pulse(d0);
      chk({24'h0, s3_hi}, 32'd2);
      chk({24'h0, s3_lo}, 32'd4);
      bus_wr(10'h19d, 8'h00, 4'hf);
      sync_pulse(d0);
      chk({24'h0, s3_hi}, 32'd3);
      chk({24'h0, s3_lo}, 32'd3);
      $display("test stage two done");

      // cascade: stage two at one event per level, each event one stage one period
      bus_wr(10'h19c, 8'h00, 4'hf);
      bus_wr(10'h19b, 8'h00, 4'hf);
      bus_wr(10'h199, 8'h51, 4'hf);
      sync_pulse(d0);
      chk({24'h0, s3_hi}, 32'd8);
      chk({24'h0, s3_lo}, 32'd8);
      bus_wr(10'h199, 8'h0f, 4'hf);
      sync_pulse(d0);
      chk({24'h0, s3_hi}, 32'd17);
      chk({24'h0, s3_lo}, 32'd17);
      $display("test cascade done");

      // start level held while sync obeyed, force only with ignore set
      bus_wr(10'h19c, 8'h03, 4'hf);
      sync_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk({31'h0, ch3_out}, 32'd1);
      bus_wr(10'h19c, 8'h0c, 4'hf);
      repeat (10) @(posedge clk);
      chk({31'h0, ch3_out}, 32'd1);
      bus_wr(10'h19c, 8'h08, 4'hf);
      repeat (10) @(posedge clk);
      chk({31'h0, ch3_out}, 32'd0);
      sync_n <= 1'b1;
      bus_wr(10'h19c, 8'h30, 4'hf);
      repeat (10) @(posedge clk);
      chk({31'h0, ch3_direct}, 32'd1);
      chk({31'h0, ch3_out}, 32'd0);
      $display("test levels done");
      test_done();
   end
endmodule
